// ---- core/ulps_phy_link.v ----
// ulps_phy_link.v: transceiver-side synchronous link interface logic
// assumes: core clock 100 MHz; link bus turned around by the testbench from the enables
// Operation
// [RQ1] with external indicator enabled, take fault level from the fault pin
// [RQ2] report fault changes to the link as receive-command status bytes
// [RQ3] link sets indicator use, complement and passthrough bits to use fault pin
// [RQ4] link enters low power before stopping the reference clock
// [RQ5] reference clock runs again before low power is left
// [RQ6] low on active-low reset pin resets all logic, clock or not
// [RQ7] link sets ignore-reset before using the shared pin as switch output
// [RQ8] drive-external-vbus set in host mode pulls power switch output low
// [RQ9] link clears drive-external-vbus when vbus state is not 11b
// [RQ10] direction is low by default, bus listened to as input
// [RQ11] direction rises to deliver usb data, status bytes, register read data
// [RQ12] direction high during power-up, reset and low-power suspend
// [RQ13] link asserts stop at end of transmit packet and register write
// [RQ14] stop while direction high drops direction in the next cycle
// [RQ15] next-data low by default; asserted to request next byte while receiving
// [RQ16] next-data high while sending marks a valid usb data byte
// [RQ17] next-data low with register read data or status bytes
// [RQ18] drive interface clock whenever a reference clock is present
// [RQ19] synchronous mode entered once the interface clock is stable
// [RQ20] link selects only one of four interface modes at a time
// [RQ21] link idles bus at zero; transfers start with a nonzero command
// [RQ22] one turnaround cycle on each direction change, bus ignored then
// [RQ23] direction high, next-data low carries a status byte except register read
// [RQ24] link drives stop high one cycle after last byte
// [RQ25] link issues reset command after clock starts
// [RQ26] device drives bus only while direction is high
`timescale 1ns/100ps
`include "ulps_map.vh"
module ulps_phy_link (
    input  wire       clock,                  // core clock, 100 MHz
    input  wire       reset,                  // synchronous reset, active high
    input  wire       reset_pin_low,          // external asynchronous reset pin, active low
    input  wire       ref_clock_present,      // reference clock toggling (pin)
    output reg        ifclk_enable,           // one-cycle pulse per interface clock edge
    output reg        sync_mode,              // synchronous mode active
    input  wire       low_power,              // low-power suspend requested
    input  wire [7:0] data_in,                // link bus level
    output reg  [7:0] data_out,               // device bus drive value
    output wire [7:0] data_oe,                // device drives bus when high
    output reg        dir,                    // direction output
    output reg        nxt,                    // next-data output
    input  wire       stp,                    // stop input (pin)
    input  wire       fault_pin,              // external vbus fault indicator
    input  wire       external_indicator_use, // use fault pin
    input  wire       indicator_complement,   // fault pin active low when set
    input  wire       indicator_passthrough,  // passthrough bit, not used by the logic
    input  wire       host_mode,              // link is in host role
    input  wire       external_vbus_drive,    // enable external vbus source
    input  wire       ignore_reset,           // shared pin used as switch output
    output wire       power_switch_out_low,   // open-drain output, value (always 0)
    output wire       power_switch_oe,        // open-drain enable: high pulls pin low
    input  wire [7:0] rx_usb_data,            // received usb byte from the deserialiser
    input  wire       rx_usb_valid,           // received usb byte offered
    output wire       rx_usb_ready,           // buffer takes the usb byte
    input  wire [7:0] reg_read_data,          // register read value from register file
    output reg        tx_data_valid,          // pulse: byte from link taken
    output reg  [7:0] tx_data,                // byte from link
    output reg        tx_end                  // pulse: stop seen at end of transfer
);
    // =====================================================
    // states, one-hot
    localparam [5:0] S_BLOCK = 6'h01; // direction held high, link blocked
    localparam [5:0] S_IDLE  = 6'h02; // listening for commands
    localparam [5:0] S_RXTA  = 6'h04; // turnaround into device drive
    localparam [5:0] S_SEND  = 6'h08; // device driving bus
    localparam [5:0] S_TXRD  = 6'h10; // link transmitting to device
    localparam [5:0] S_BACK  = 6'h20; // turnaround back to link drive

    reg  [5:0] state;
    reg  [5:0] next_state;
    reg  [7:0] stable_cnt;
    reg  [7:0] acc;
    reg  [1:0] cmd_kind;
    reg        read_pend;
    reg  [1:0] vbus_last;
    reg        ext_rst_q;
    wire       stp_s;
    wire       fault_s;
    wire       ref_s;
    wire       rst_pin_s;
    wire [8:0] buf_data;
    wire       buf_valid;
    reg        buf_pop;

    // pins cross two flops before logic sees them
    // stop is launched by the link on our own interface edges, like data_in, so it is read directly:
    // two flops here would push it past the edge that must end the transfer or the abort
    assign stp_s = stp;
    ulps_sync2 u_fault (.clock(clock), .reset(reset), .reset_val(1'b0), .level_in(fault_pin), .level_out(fault_s));
    ulps_sync2 u_ref   (.clock(clock), .reset(reset), .reset_val(1'b0), .level_in(ref_clock_present),
                        .level_out(ref_s));
    ulps_sync2 u_rstp  (.clock(clock), .reset(reset), .reset_val(1'b0), .level_in(~reset_pin_low),
                        .level_out(rst_pin_s));

    // usb receive bytes are buffered so a link stop or a status byte loses none
    ulps_buf2 u_rxbuf (
        .clock     (clock),
        .reset     (reset | ext_rst_q),
        .in_data   ({1'b1, rx_usb_data}),
        .in_valid  (rx_usb_valid),
        .in_ready  (rx_usb_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_pop)
    );

    // =====================================================
    // function: vbus state as seen through the indicator options
    function [1:0] vbus_state;
        input use_ext;
        input compl;
        input fault_lvl;
        begin
            if (use_ext && (fault_lvl ^ compl))
                vbus_state = `ULPS_VBUS_FAULT;
            else
                vbus_state = `ULPS_VBUS_GOOD;
        end
    endfunction

    wire [1:0] vbus_now = vbus_state(external_indicator_use, indicator_complement, fault_s); // RQ1
    wire       vbus_chg = (vbus_now != vbus_last);

    // external reset pin acts unless the pin is repurposed as the switch output
    always @(posedge clock) begin
        if (reset)
            ext_rst_q <= 1'b0;
        else
            ext_rst_q <= rst_pin_s && !ignore_reset; // RQ6
    end
    wire any_reset = reset | ext_rst_q;

    // open-drain switch: only ever pulls low, released otherwise
    assign power_switch_out_low = 1'b0;
    assign power_switch_oe      = host_mode && external_vbus_drive && ignore_reset; // RQ8

    // =====================================================
    // interface clock enable: fractional divider, 60 of every 100 edges
    always @(posedge clock) begin
        if (any_reset || !ref_s) begin
            acc          <= 8'h00;
            ifclk_enable <= 1'b0;
        end else if (acc + `ULPS_IFCLK_STEP >= `ULPS_IFCLK_MOD) begin
            acc          <= acc + `ULPS_IFCLK_STEP - `ULPS_IFCLK_MOD;
            ifclk_enable <= 1'b1; // RQ18
        end else begin
            acc          <= acc + `ULPS_IFCLK_STEP;
            ifclk_enable <= 1'b0;
        end
    end

    // stability count: sync mode only once the clock has run a while
    always @(posedge clock) begin
        if (any_reset || !ref_s) begin
            stable_cnt <= 8'h00;
            sync_mode  <= 1'b0;
        end else if (stable_cnt != `ULPS_CLK_STABLE) begin
            stable_cnt <= stable_cnt + 8'h01;
        end else begin
            sync_mode  <= 1'b1; // RQ19
        end
    end

    // =====================================================
    // next-state logic; everything advances on interface clock edges
    always @* begin
        next_state = state;
        case (state)
            S_BLOCK: if (sync_mode && !low_power) next_state = S_BACK;
            S_IDLE: begin
                if (low_power)
                    next_state = S_BLOCK; // RQ12
                else if (data_in != 8'h00)
                    next_state = S_TXRD;
                else if (buf_valid || vbus_chg || read_pend)
                    next_state = S_RXTA; // RQ11
            end
            S_RXTA: next_state = stp_s ? S_BACK : S_SEND;
            S_SEND: begin
                if (stp_s)
                    next_state = S_BACK; // RQ14
                else if (!buf_valid && !vbus_chg && !read_pend)
                    next_state = S_BACK;
            end
            S_TXRD: begin
                // a register read ends with no stop: turn around once the command is taken
                if (cmd_kind == `ULPS_CMD_REG_READ)
                    next_state = S_RXTA; // RQ11
                else if (stp_s)
                    next_state = S_IDLE;
            end
            S_BACK: next_state = S_IDLE; // RQ22
            default: next_state = S_BLOCK;
        endcase
    end

    // =====================================================
    // state register and bus drive
    always @(posedge clock) begin
        if (any_reset || !sync_mode) begin
            state         <= S_BLOCK;
            dir           <= 1'b1; // RQ12
            nxt           <= 1'b0;
            data_out      <= 8'h00;
            cmd_kind      <= 2'h0;
            read_pend     <= 1'b0;
            vbus_last     <= `ULPS_VBUS_GOOD;
            tx_data_valid <= 1'b0;
            tx_data       <= 8'h00;
            tx_end        <= 1'b0;
        end else begin
            tx_data_valid <= 1'b0;
            tx_end        <= 1'b0;
            if (ifclk_enable) begin
                state <= next_state;
                // direction follows state: high only in block, turnaround into device drive and send
                dir   <= (next_state == S_RXTA) || (next_state == S_SEND) || (next_state == S_BLOCK); // RQ10
                nxt   <= 1'b0; // RQ15
                case (next_state)
                    S_TXRD: begin
                        if (state == S_IDLE)
                            cmd_kind <= data_in[`ULPS_CMD_TYPE_HI:`ULPS_CMD_TYPE_LO];
                        if (state == S_TXRD) begin
                            tx_data_valid <= 1'b1;
                            tx_data       <= data_in;
                        end
                        nxt <= 1'b1; // RQ15
                    end
                    S_SEND: begin
                        if (read_pend) begin
                            data_out  <= reg_read_data; // RQ17
                            read_pend <= 1'b0;
                        end else if (buf_valid) begin
                            data_out <= buf_data[7:0];
                            nxt      <= 1'b1; // RQ16
                        end else begin
                            data_out  <= {4'h0, vbus_now, 2'h0}; // RQ23
                            vbus_last <= vbus_now; // RQ2
                        end
                    end
                    default: data_out <= 8'h00;
                endcase
                if (state == S_TXRD && next_state != S_TXRD) begin
                    tx_end    <= (cmd_kind != `ULPS_CMD_REG_READ);
                    read_pend <= (cmd_kind == `ULPS_CMD_REG_READ);
                end
            end
        end
    end

    // pop a usb byte at the edge it is loaded onto the bus
    always @* begin
        buf_pop = ifclk_enable && sync_mode && !any_reset && (next_state == S_SEND) && !read_pend && buf_valid;
    end

    // drive only in the send state: turnaround cycles leave the bus undriven
    assign data_oe = (state == S_SEND) ? 8'hff : 8'h00; // RQ26
endmodule // ulps_phy_link

// ---- core/ulps_map.vh ----
// ulps_map.vh: constants for the transceiver-side synchronous link interface
// assumes: included by the design files of the ulps block only
`ifndef ULPS_MAP_VH
`define ULPS_MAP_VH

// =====================================================
// clock and timing
`define ULPS_CLK_MHZ        100
`define ULPS_IFCLK_MHZ      60
// interface clock enable: accumulator step and modulus (60/100 of edges)
`define ULPS_IFCLK_STEP     8'h3c
`define ULPS_IFCLK_MOD      8'h64
// cycles the reference clock must toggle before the interface is declared stable
`define ULPS_CLK_STABLE     8'h20

// =====================================================
// transmit command byte fields
`define ULPS_CMD_TYPE_HI    7
`define ULPS_CMD_TYPE_LO    6
`define ULPS_CMD_TRANSMIT   2'h1
`define ULPS_CMD_REG_WRITE  2'h2
`define ULPS_CMD_REG_READ   2'h3

// =====================================================
// receive command byte fields
`define ULPS_RXCMD_VBUS_HI  3
`define ULPS_RXCMD_VBUS_LO  2
`define ULPS_VBUS_GOOD      2'h3
`define ULPS_VBUS_FAULT     2'h0

`endif

// ---- core/ulps_sync2.v ----
// ulps_sync2.v: two-stage synchroniser for a single level
// assumes: input may come from any clock domain or pin
`timescale 1ns/100ps
module ulps_sync2 (
    input  wire clock,     // core clock
    input  wire reset,     // synchronous reset, active high
    input  wire reset_val, // value taken during reset
    input  wire level_in,  // asynchronous level
    output reg  level_out  // synchronised level
);
    reg stage1;

    // =====================================================
    // first stage is read only by the second stage
    always @(posedge clock) begin
        if (reset) begin
            stage1    <= reset_val;
            level_out <= reset_val;
        end else begin
            stage1    <= level_in;
            level_out <= stage1;
        end
    end
endmodule // ulps_sync2

// ---- core/ulps_buf2.v ----
// ulps_buf2.v: two-entry buffer with valid and ready on both sides
// assumes: both sides on the core clock
`timescale 1ns/100ps
module ulps_buf2 (
    input  wire       clock,     // core clock
    input  wire       reset,     // synchronous reset, active high
    input  wire [8:0] in_data,   // {is_usb_data, byte}
    input  wire       in_valid,  // filler offers a word
    output wire       in_ready,  // buffer can take a word
    output wire [8:0] out_data,  // oldest word
    output wire       out_valid, // a word is held
    input  wire       out_ready  // drain takes the word
);
    reg [8:0] slot [0:1];
    reg       rd_ptr;
    reg       wr_ptr;
    reg [1:0] count;
    wire      push = in_valid && in_ready;
    wire      pop  = out_valid && out_ready;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = slot[rd_ptr];

    // =====================================================
    // pointers and occupancy; a full buffer holds off the filler
    always @(posedge clock) begin
        if (reset) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                slot[wr_ptr] <= in_data;
                wr_ptr       <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                count <= count + 2'h1;
            else if (pop && !push)
                count <= count - 2'h1;
        end
    end
endmodule // ulps_buf2

// ---- tb/ulps_phy_link_properties.sv ----
// ulps_phy_link_properties.sv: port checks of the link interface logic
// assumes: bound to ulps_phy_link; one core clock, synchronous reset
`timescale 1ns/100ps
// ==========================================
// checker
module ulps_phy_link_properties (
    input wire logic       clock,                // core clock
    input wire logic       reset,                // sync reset
    input wire logic       reset_pin_low,        // reset pin
    input wire logic       ref_clock_present,    // ref clock
    input wire logic       ifclk_enable,         // if edge
    input wire logic       sync_mode,            // sync mode
    input wire logic       low_power,            // suspend
    input wire logic [7:0] data_in,              // bus level
    input wire logic [7:0] data_oe,              // bus enable
    input wire logic       dir,                  // direction
    input wire logic       nxt,                  // next data
    input wire logic       stp,                  // stop
    input wire logic       host_mode,            // host role
    input wire logic       external_vbus_drive,  // vbus bit
    input wire logic       ignore_reset,         // pin reuse
    input wire logic       power_switch_out_low, // switch value
    input wire logic       power_switch_oe       // switch enable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // stop from the link while the device owns the bus
    sequence s_abort;
        sync_mode && dir && !low_power && reset_pin_low && $rose(stp);
    endsequence
    // nonzero command other than a register read while idle
    sequence s_tx_cmd;
        sync_mode && !dir && !nxt && !low_power && reset_pin_low && data_in != 8'h00 && data_in[7:6] != 2'b11;
    endsequence
    a_reset_dir_high: assert property ($fell(reset) |-> dir && !nxt && data_oe == 8'h00)
        else $error("dir not high after reset");
    a_stable_wait: assert property ($fell(reset) |-> (!sync_mode) [*8])
        else $error("sync mode before clock stable");
    a_suspend_dir: assert property ($rose(low_power) |-> ##[1:6] dir)
        else $error("dir not high in suspend");
    a_cmd_accept: assert property (s_tx_cmd |-> ##[1:6] nxt)
        else $error("command not throttled by nxt");
    a_stop_abort: assert property (s_abort |-> ##[1:8] !dir)
        else $error("dir not dropped after stop");
    a_bus_owner: assert property (data_oe != 8'h00 |-> dir)
        else $error("device drives bus with dir low");
    a_turn_quiet: assert property ($rose(dir) |-> data_oe == 8'h00)
        else $error("bus driven in turnaround");
    a_usb_byte_drv: assert property (dir && nxt |-> data_oe == 8'hff)
        else $error("usb byte flagged without drive");
    a_switch_pull: assert property (host_mode && external_vbus_drive && ignore_reset |-> power_switch_oe && !power_switch_out_low)
        else $error("power switch not pulled low");
    // rate above one half means no two idle edges in a row
    a_ifclk_gap: assert property (sync_mode && reset_pin_low && ref_clock_present && !ifclk_enable |=> ifclk_enable || !ref_clock_present || !reset_pin_low)
        else $error("interface clock edge missing");
endmodule // ulps_phy_link_properties

// ---- tb/ulps_link_model.sv ----
// ulps_link_model.sv: behavioural link controller on the far side of the bus
// assumes: the bench turns the bus around from dir and the device enables
`timescale 1ns/100ps
// ==========================================
// link model
module ulps_link_model (
    input  wire logic       clock,        // core clock
    input  wire logic       ifclk_enable, // interface edge
    input  wire logic       dir,          // direction
    input  wire logic       nxt,          // next data
    output logic      [7:0] link_data,    // link drive
    output logic            stp           // stop
);
    // idle bus is all zero
    initial begin
        link_data = 8'h00;
        stp = 1'b0;
    end
    // wait for an interface edge where a masked {any, dir, nxt} is high
    task automatic take(input logic [2:0] want);
        int i;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (!(ifclk_enable && (want & {1'b1, dir, nxt}) != 3'h0) && i < 400);
    endtask
    // command, n bytes counting up from b0, then an optional one-edge stop
    task automatic send(input logic [7:0] cmd, input int n, input logic [7:0] b0, input logic [1:0] want,
                        input logic stop);
        int k;
        take(3'b100);
        link_data <= cmd;
        take({1'b0, want});
        for (k = 0; k < n; k++) begin
            link_data <= b0 + 8'(k);
            take(3'b001);
        end
        link_data <= 8'h00;
        if (stop) begin
            stp <= 1'b1;
            take(3'b100);
            stp <= 1'b0;
        end
    endtask
    // stop while the device owns the bus; the bus itself is not read here
    task automatic abort();
        stp <= 1'b1;
        take(3'b100);
        stp <= 1'b0;
    endtask
endmodule // ulps_link_model

// ---- tb/ulps_phy_link_tb.sv ----
// ulps_phy_link_tb.sv: self-checking bench of the transceiver link logic
// assumes: design under core/, link model and checker under tb/
`timescale 1ns/100ps
// ==========================================
// bench top
module ulps_phy_link_tb;
    logic       clock = 1'b0, reset = 1'b1, reset_pin_low = 1'b1, ref_clock_present = 1'b1, low_power = 1'b0;
    logic       fault_pin = 1'b0, external_indicator_use = 1'b0, indicator_complement = 1'b0;
    logic       indicator_passthrough = 1'b0, host_mode = 1'b0, external_vbus_drive = 1'b0, ignore_reset = 1'b0;
    logic       rx_usb_valid = 1'b0, refused = 1'b0;
    logic [7:0] rx_usb_data = 8'h00, reg_read_data = 8'h5a, last_stat = 8'h00;
    logic [7:0] txq[$], rxq[$];
    wire  [7:0] data_in, data_out, data_oe, tx_data, link_data;
    wire        ifclk_enable, sync_mode, dir, nxt, stp, power_switch_out_low, power_switch_oe;
    wire        rx_usb_ready, tx_data_valid, tx_end;
    int         err_total = 0, total_checks = 0, stat_n = 0, end_n = 0;
    initial forever #5 clock = ~clock;
    // weak pull-downs leave released lines low; the link drives only while dir is low
    assign data_in = (data_out & data_oe) | (link_data & ~data_oe & {8{~dir}});
    ulps_phy_link dut_u (.clock, .reset, .reset_pin_low, .ref_clock_present, .ifclk_enable, .sync_mode, .low_power,
        .data_in, .data_out, .data_oe, .dir, .nxt, .stp, .fault_pin, .external_indicator_use, .indicator_complement,
        .indicator_passthrough, .host_mode, .external_vbus_drive, .ignore_reset, .power_switch_out_low,
        .power_switch_oe, .rx_usb_data, .rx_usb_valid, .rx_usb_ready, .reg_read_data, .tx_data_valid, .tx_data, .tx_end);
    ulps_link_model link_u (.clock, .ifclk_enable, .dir, .nxt, .link_data, .stp);
    // bytes are captured at the interface edge that takes them
    always @(posedge clock) begin
        if (tx_data_valid) txq.push_back(tx_data);
        if (tx_end) end_n++;
        if (ifclk_enable && dir && data_oe == 8'hff && nxt) rxq.push_back(data_out);
        if (ifclk_enable && dir && data_oe == 8'hff && !nxt) begin
            last_stat = data_out;
            stat_n++;
        end
        if (!rx_usb_ready) refused = 1'b1;
    end
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic wait_dir(input logic v, input int lim);
        int i;
        for (i = 0; i < lim && dir !== v; i++) @(posedge clock);
    endtask
    task automatic wait_sync();
        int i;
        for (i = 0; i < 300 && sync_mode !== 1'b1; i++) @(posedge clock);
        chk(8'h01, {7'h0, sync_mode});
    endtask
    // offers bytes and holds each until the buffer takes it
    task automatic feed(input int n, input logic [7:0] b0);
        int i;
        for (i = 0; i < n; i++) begin
            rx_usb_data <= b0 + 8'(i);
            rx_usb_valid <= 1'b1;
            do @(posedge clock); while (rx_usb_ready !== 1'b1);
        end
        rx_usb_valid <= 1'b0;
    endtask
    task automatic tx_run(input logic [7:0] cmd, input int n, input logic [7:0] b0);
        int i;
        txq.delete();
        end_n = 0;
        link_u.send(cmd, n, b0, 2'b01, 1'b1);
        for (i = 0; i < 50 && end_n == 0; i++) @(posedge clock);
        chk(8'(n + 1), 8'(txq.size()));
        for (i = 0; i <= n && i < txq.size(); i++) chk(i == 0 ? cmd : b0 + 8'(i - 1), txq[i]);
        chk(8'h01, 8'(end_n));
    endtask
    task automatic rx_run(input int n, input logic [7:0] b0);
        int i;
        rxq.delete();
        refused = 1'b0;
        feed(n, b0);
        wait_dir(1'b0, 400);
        chk(8'(n), 8'(rxq.size()));
        for (i = 0; i < n && i < rxq.size(); i++) chk(b0 + 8'(i), rxq[i]);
        chk(8'h01, {7'h0, refused});
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        int i, j, n0;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        chk(8'h02, {6'h0, dir, nxt});
        wait_sync();
        wait_dir(1'b0, 300);
        chk(8'h00, {6'h0, dir, nxt});
        tx_run(8'h84, 1, 8'h20);
        tx_run(8'h43, 3, 8'h10);
        rx_run(6, 8'ha0);
        // register read: command, turnaround, data with nxt low, back
        link_u.send(8'hc4, 0, 8'h00, 2'b11, 1'b0);
        wait_dir(1'b1, 50);
        wait_dir(1'b0, 50);
        chk(reg_read_data, last_stat);
        fork
            feed(8, 8'h30);
        join_none
        wait_dir(1'b1, 50);
        link_u.abort();
        wait_dir(1'b0, 8);
        chk(8'h00, {7'h0, dir});
        wait fork;
        wait_dir(1'b1, 20);
        wait_dir(1'b0, 400);
        for (i = 0; i < 8; i++) begin
            {host_mode, external_vbus_drive, ignore_reset} <= 3'(i);
            repeat (2) @(posedge clock);
            chk({7'h0, i == 7}, {power_switch_out_low, 6'h0, power_switch_oe});
        end
        ignore_reset <= 1'b0;
        reset_pin_low <= 1'b0;
        wait_dir(1'b1, 8);
        chk(8'h02, {6'h0, dir, nxt});
        reset_pin_low <= 1'b1;
        wait_sync();
        low_power <= 1'b1;
        wait_dir(1'b1, 8);
        repeat (8) @(posedge clock); // suspend reached before the reference stops
        ref_clock_present <= 1'b0;
        repeat (4) @(posedge clock);
        chk(8'h02, {6'h0, dir, ifclk_enable});
        ref_clock_present <= 1'b1;
        wait_sync();
        low_power <= 1'b0;
        wait_dir(1'b0, 300);
        chk(8'h00, {7'h0, dir});
        external_indicator_use <= 1'b1;
        indicator_passthrough <= 1'b1;
        for (i = 0; i < 4; i++) begin
            n0 = stat_n;
            indicator_complement <= i[1];
            fault_pin <= i[0] ~^ i[1];
            for (j = 0; j < 300 && stat_n == n0; j++) @(posedge clock);
            chk({4'h0, i[0] ? 2'h3 : 2'h0, 2'h0}, {4'h0, last_stat[3:2], 2'h0});
            external_vbus_drive <= 1'b0;
        end
        results();
    end
    // hang guard, well above the few hundred cycles the sequence needs
    initial begin
        #200000;
        err_total++;
        results();
    end
endmodule // ulps_phy_link_tb
bind ulps_phy_link ulps_phy_link_properties chk_u (.clock, .reset, .reset_pin_low, .ref_clock_present, .ifclk_enable,
    .sync_mode, .low_power, .data_in, .data_oe, .dir, .nxt, .stp, .host_mode, .external_vbus_drive, .ignore_reset,
    .power_switch_out_low, .power_switch_oe);
